/* File: common/ltm_pkg.sv */
// Package for the load threshold monitor: register map, fields, timing.
// Assumes a 32-bit APB slave on a 20 MHz pclk.
package ltm_pkg;

    // ********************************************************************
    // Register map (byte addresses)
    // ********************************************************************
    localparam logic [11:0] LTM_OFS_CTRL   = 12'h000;
    localparam logic [11:0] LTM_OFS_LOWTH  = 12'h004;
    localparam logic [11:0] LTM_OFS_LOWDLY = 12'h008;
    localparam logic [11:0] LTM_OFS_HIGHTH = 12'h00C;
    localparam logic [11:0] LTM_OFS_HIGHDLY= 12'h010;
    localparam logic [11:0] LTM_OFS_SETTLE = 12'h014;
    localparam logic [11:0] LTM_OFS_STATUS = 12'h018;
    localparam logic [11:0] LTM_OFS_IRQST  = 12'h01C;
    localparam logic [11:0] LTM_OFS_IRQMSK = 12'h020;

    // ********************************************************************
    // Fields
    // ********************************************************************
    localparam int LTM_CTRL_MODE   = 0;
    localparam int LTM_CTRL_ENCFG  = 1;
    localparam int LTM_CTRL_OUTCFG = 2;
    localparam int LTM_PCT_W       = 8;
    localparam int LTM_SEC_W       = 16;
    localparam int LTM_IRQ_W       = 3;
    localparam int LTM_IRQ_RISE    = 0;
    localparam int LTM_IRQ_FALL    = 1;
    localparam int LTM_IRQ_SETTLED = 2;

    // ********************************************************************
    // Reset values: low-power mode, 0 % threshold, output assigned
    // ********************************************************************
    localparam logic [LTM_PCT_W-1:0] LTM_PCT_RST  = 8'h00;
    localparam logic [LTM_SEC_W-1:0] LTM_SEC_RST  = 16'h0000;
    localparam logic                 LTM_MODE_LOW = 1'b0;
    localparam logic                 LTM_MODE_HIGH= 1'b1;
    localparam logic                 LTM_OUTCFG_RST = 1'b1;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int LTM_CLK_HZ       = 20_000_000;
    localparam int LTM_SEC_PERIOD_S = 1;
    localparam int LTM_SEC_CYCLES   = LTM_CLK_HZ * LTM_SEC_PERIOD_S;
    localparam int LTM_PRE_W        = 25;

    typedef struct packed {
        logic                 mode;
        logic                 en_cfg;
        logic                 out_cfg;
        logic [LTM_PCT_W-1:0] low_th;
        logic [LTM_SEC_W-1:0] low_dly;
        logic [LTM_PCT_W-1:0] high_th;
        logic [LTM_SEC_W-1:0] high_dly;
        logic [LTM_SEC_W-1:0] settle;
    } ltm_cfg_s;

    typedef enum logic [1:0] {
        LTM_IDLE   = 2'b00,
        LTM_SETTLE = 2'b01,
        LTM_WATCH  = 2'b10
    } ltm_state_e;

endpackage

/* File: core/ltm_sec_tick.sv */
// Seconds tick generator.
// Assumes pclk at the package rate; prescale is a parameter to shorten sims.
`timescale 1ns/10ps
module ltm_sec_tick #(
    parameter int SEC_CYCLES = ltm_pkg::LTM_SEC_CYCLES
) (
    input  wire logic pclk,    // Clock
    input  wire logic presetn, // Async reset, low
    input  wire logic ce,      // Clock enable
    output logic      tick     // One-cycle pulse per second
);
    import ltm_pkg::*;

    localparam logic [LTM_PRE_W-1:0] TOP = LTM_PRE_W'(SEC_CYCLES - 1);
    logic [LTM_PRE_W-1:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (ce) begin
            tick  <= (cnt_r == TOP);
            cnt_r <= (cnt_r == TOP) ? '0 : cnt_r + 1'b1;
        end
    end
endmodule

/* File: core/ltm_qual_timer.sv */
// Qualifying timer: counts whole seconds while a condition holds.
// Assumes tick is a one-cycle pulse; restarts whenever cond drops.
`timescale 1ns/10ps
module ltm_qual_timer (
    input  wire logic                          pclk,    // Clock
    input  wire logic                          presetn, // Async reset, low
    input  wire logic                          ce,      // Clock enable
    input  wire logic                          clr,     // Synchronous restart
    input  wire logic                          cond,    // Condition holds
    input  wire logic                          tick,    // Seconds tick
    input  wire logic [ltm_pkg::LTM_SEC_W-1:0] dly,     // Delay in seconds
    output logic                               done     // Condition qualified
);
    import ltm_pkg::*;

    logic [LTM_SEC_W-1:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (ce) begin
            if (clr || !cond) begin
                cnt_r <= '0;
            end else if (tick && cnt_r != dly) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign done = cond && !clr && (cnt_r == dly);
endmodule

/* File: core/ltm_top.sv */
// Load threshold monitor with APB register file and interrupt.
// Assumes power_pct is synchronous to pclk, in percent of rated power.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module ltm_top #(
    parameter int SEC_CYCLES = ltm_pkg::LTM_SEC_CYCLES
) (
    input  wire logic                          pclk,                   // APB clock
    input  wire logic                          presetn,                // Async reset, low
    input  wire logic                          ce,                     // Clock enable
    input  wire logic                          psel,                   // APB select
    input  wire logic                          penable,                // APB enable
    input  wire logic                          pwrite,                 // APB direction
    input  wire logic [11:0]                   paddr,                  // APB address
    input  wire logic [31:0]                   pwdata,                 // APB write data
    output logic      [31:0]                   prdata,                 // APB read data
    output logic                               pready,                 // APB ready
    output logic                               pslverr,                // APB error
    input  wire logic [ltm_pkg::LTM_PCT_W-1:0] power_pct,              // Active power, %
    input  wire logic                          threshold_enable_input, // Enable contact
    output logic                               load_threshold_output,  // Digital output
    output logic                               irq                     // Interrupt level
);
    import ltm_pkg::*;

    // ********************************************************************
    // Registers
    // ********************************************************************
    ltm_cfg_s             cfg_r;
    logic [LTM_IRQ_W-1:0] irq_st_r;
    logic [LTM_IRQ_W-1:0] irq_msk_r;
    logic [LTM_SEC_W-1:0] settle_cnt_r;
    ltm_state_e           state_r;
    logic                 out_r;
    logic                 en_d_r;

    logic                 wr_en;
    logic                 rd_en;
    logic                 addr_ok;
    logic [31:0]          rd_nxt;
    logic                 tick;
    logic                 active;
    logic                 valid_th;
    logic                 below_low;
    logic                 above_high;
    logic                 set_cond;
    logic                 clr_cond;
    logic                 set_done;
    logic                 clr_done;
    logic                 run;
    logic                 en_rise;
    logic                 timer_clr;
    logic [LTM_SEC_W-1:0] set_dly;
    logic [LTM_SEC_W-1:0] clr_dly;
    logic [LTM_IRQ_W-1:0] ev;

    // ********************************************************************
    // APB decode
    // ********************************************************************
    // Zero-wait slave: every access completes in its first access cycle
    assign wr_en = psel && penable && pwrite && ce;
    assign rd_en = psel && !penable && !pwrite && ce;

    always_comb begin
        addr_ok = 1'b1;
        rd_nxt  = 32'h0000_0000;
        unique case (paddr)
            LTM_OFS_CTRL: begin
                rd_nxt[LTM_CTRL_MODE]   = cfg_r.mode;
                rd_nxt[LTM_CTRL_ENCFG]  = cfg_r.en_cfg;
                rd_nxt[LTM_CTRL_OUTCFG] = cfg_r.out_cfg;
            end
            LTM_OFS_LOWTH:   rd_nxt[LTM_PCT_W-1:0] = cfg_r.low_th;
            LTM_OFS_LOWDLY:  rd_nxt[LTM_SEC_W-1:0] = cfg_r.low_dly;
            LTM_OFS_HIGHTH:  rd_nxt[LTM_PCT_W-1:0] = cfg_r.high_th;
            LTM_OFS_HIGHDLY: rd_nxt[LTM_SEC_W-1:0] = cfg_r.high_dly;
            LTM_OFS_SETTLE:  rd_nxt[LTM_SEC_W-1:0] = cfg_r.settle;
            LTM_OFS_STATUS:  rd_nxt[3:0] = {state_r, valid_th, out_r};
            LTM_OFS_IRQST:   rd_nxt[LTM_IRQ_W-1:0] = irq_st_r;
            LTM_OFS_IRQMSK:  rd_nxt[LTM_IRQ_W-1:0] = irq_msk_r;
            default:         addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en) begin
                prdata <= rd_nxt;
            end
        end
    end

    // ********************************************************************
    // Configuration writes
    // ********************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r.mode     <= LTM_MODE_LOW;
            cfg_r.en_cfg   <= 1'b0;
            cfg_r.out_cfg  <= LTM_OUTCFG_RST;
            cfg_r.low_th   <= LTM_PCT_RST;
            cfg_r.low_dly  <= LTM_SEC_RST;
            cfg_r.high_th  <= LTM_PCT_RST;
            cfg_r.high_dly <= LTM_SEC_RST;
            cfg_r.settle   <= LTM_SEC_RST;
            irq_msk_r      <= '0;
        end else if (wr_en && pready) begin
            unique case (paddr)
                LTM_OFS_CTRL: begin
                    cfg_r.mode    <= pwdata[LTM_CTRL_MODE];
                    cfg_r.en_cfg  <= pwdata[LTM_CTRL_ENCFG];
                    cfg_r.out_cfg <= pwdata[LTM_CTRL_OUTCFG];
                end
                LTM_OFS_LOWTH:   cfg_r.low_th   <= pwdata[LTM_PCT_W-1:0];
                LTM_OFS_LOWDLY:  cfg_r.low_dly  <= pwdata[LTM_SEC_W-1:0];
                LTM_OFS_HIGHTH:  cfg_r.high_th  <= pwdata[LTM_PCT_W-1:0];
                LTM_OFS_HIGHDLY: cfg_r.high_dly <= pwdata[LTM_SEC_W-1:0];
                LTM_OFS_SETTLE:  cfg_r.settle   <= pwdata[LTM_SEC_W-1:0];
                LTM_OFS_IRQMSK:  irq_msk_r      <= pwdata[LTM_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // ********************************************************************
    // Conditions
    // ********************************************************************
    assign valid_th = (cfg_r.low_th != '0) && (cfg_r.high_th != '0)
                    && (cfg_r.low_th < cfg_r.high_th);
    assign active  = (!cfg_r.en_cfg || threshold_enable_input);
    assign run     = active && valid_th && cfg_r.out_cfg;
    assign en_rise = cfg_r.en_cfg && threshold_enable_input && !en_d_r;

    assign below_low  = power_pct < cfg_r.low_th;
    assign above_high = power_pct > cfg_r.high_th;

    // Low mode sets on low power, high mode on high power
    assign set_cond = (cfg_r.mode == LTM_MODE_HIGH) ? above_high : below_low;
    assign clr_cond = (cfg_r.mode == LTM_MODE_HIGH) ? below_low : above_high;
    assign set_dly  = (cfg_r.mode == LTM_MODE_HIGH) ? cfg_r.high_dly : cfg_r.low_dly;
    assign clr_dly  = (cfg_r.mode == LTM_MODE_HIGH) ? cfg_r.low_dly : cfg_r.high_dly;
    assign timer_clr = (state_r != LTM_WATCH) || !run;

    ltm_sec_tick #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .tick    (tick)
    );

    ltm_qual_timer u_set (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .clr     (timer_clr),
        .cond    (set_cond && !out_r),
        .tick    (tick),
        .dly     (set_dly),
        .done    (set_done)
    );

    ltm_qual_timer u_clr (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .clr     (timer_clr),
        .cond    (clr_cond && out_r),
        .tick    (tick),
        .dly     (clr_dly),
        .done    (clr_done)
    );

    // ********************************************************************
    // Sequencer and output
    // ********************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_d_r <= 1'b0;
        end else if (ce) begin
            en_d_r <= threshold_enable_input;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= LTM_IDLE;
            settle_cnt_r <= '0;
        end else if (ce) begin
            unique case (state_r)
                LTM_IDLE: begin
                    if (run) begin
                        // Settle only after an enable edge, not for a free-running start
                        state_r <= en_rise ? LTM_SETTLE : LTM_WATCH;
                        settle_cnt_r <= '0;
                    end
                end
                LTM_SETTLE: begin
                    if (!run) begin
                        state_r <= LTM_IDLE;
                    end else if (settle_cnt_r >= cfg_r.settle) begin
                        state_r <= LTM_WATCH;
                    end else if (tick) begin
                        settle_cnt_r <= settle_cnt_r + 1'b1;
                    end
                end
                LTM_WATCH: begin
                    if (!run) begin
                        state_r <= LTM_IDLE;
                    end
                end
                default: state_r <= LTM_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_r <= 1'b0;
        end else if (ce) begin
            if (state_r != LTM_WATCH || !run) begin
                out_r <= 1'b0;
            end else if (set_done) begin
                out_r <= 1'b1;
            end else if (clr_done) begin
                out_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_threshold_output <= 1'b0;
        end else if (ce) begin
            load_threshold_output <= out_r;
        end
    end

    // ********************************************************************
    // Interrupts
    // ********************************************************************
    assign ev[LTM_IRQ_RISE]    = set_done && !out_r && state_r == LTM_WATCH && run;
    assign ev[LTM_IRQ_FALL]    = out_r && (clr_done || !run || state_r != LTM_WATCH);
    assign ev[LTM_IRQ_SETTLED] = (state_r == LTM_SETTLE) && run
                               && (settle_cnt_r >= cfg_r.settle);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_r <= '0;
        end else if (ce) begin
            // New events win over a simultaneous write-one clear
            if (wr_en && pready && paddr == LTM_OFS_IRQST) begin
                irq_st_r <= (irq_st_r & ~pwdata[LTM_IRQ_W-1:0]) | ev;
            end else begin
                irq_st_r <= irq_st_r | ev;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(irq_st_r & irq_msk_r);
        end
    end
endmodule

/* File: testbench/ltm_plant.sv */
// Far-side model: power measurement and enable contact stage.
// Assumes the bench sets the wanted power and contact state.
`timescale 1ns/10ps
module ltm_plant (
    input  wire logic                          pclk,       // Clock
    input  wire logic                          presetn,    // Async reset, low
    input  wire logic [ltm_pkg::LTM_PCT_W-1:0] pwr_req,    // Wanted power, %
    input  wire logic                          en_req,     // Wanted contact state
    output logic      [ltm_pkg::LTM_PCT_W-1:0] power_pct,  // Measured power, %
    output logic                               en_contact  // Contact as seen
);
    // Measurement lags one sample, like a real converter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_pct  <= '0;
            en_contact <= 1'b0;
        end else begin
            power_pct  <= pwr_req;
            en_contact <= en_req;
        end
    end
endmodule

/* File: testbench/ltm_top_asserts.sv */
// Checker for the load threshold monitor top, attached by bind.
// Assumes ce held high and a single APB master.
`timescale 1ns/10ps
module ltm_top_asserts
    import ltm_pkg::*;
#(
    parameter int SEC_CYCLES = LTM_SEC_CYCLES
) (
    input wire logic                 pclk,                   // Clock
    input wire logic                 presetn,                // Reset, low
    input wire logic                 ce,                     // Clock enable
    input wire logic                 psel,                   // APB select
    input wire logic                 penable,                // APB enable
    input wire logic                 pwrite,                 // APB direction
    input wire logic [11:0]          paddr,                  // APB address
    input wire logic [31:0]          pwdata,                 // APB write data
    input wire logic [31:0]          prdata,                 // APB read data
    input wire logic                 pready,                 // APB ready
    input wire logic                 pslverr,                // APB error
    input wire logic [LTM_PCT_W-1:0] power_pct,              // Power, %
    input wire logic                 threshold_enable_input, // Enable contact
    input wire logic                 load_threshold_output,  // Output
    input wire logic                 irq                     // Interrupt
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // Shadow of the configuration writes
    // ****************************************
    logic           acc_wr;
    logic           mode_q, en_q, asg_q, run_ok;
    logic     [7:0] lo_q, hi_q;
    logic    [15:0] set_q;
    logic     [2:0] live_q;
    assign acc_wr = psel && penable && pready && pwrite;
    assign run_ok = asg_q && lo_q != 0 && hi_q != 0 && lo_q < hi_q
                    && (!en_q || threshold_enable_input);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mode_q, en_q, asg_q, lo_q, hi_q, set_q} <= {3'b001, 32'h0};
        end else if (acc_wr) begin
            case (paddr)
                LTM_OFS_CTRL:   {asg_q, en_q, mode_q} <= pwdata[2:0];
                LTM_OFS_LOWTH:  lo_q <= pwdata[7:0];
                LTM_OFS_HIGHTH: hi_q <= pwdata[7:0];
                LTM_OFS_SETTLE: set_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end
    // Quiet time after any config change, so lag never trips the cause checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) live_q <= '0;
        else if (acc_wr || !run_ok) live_q <= '0;
        else if (live_q != 3'd7) live_q <= live_q + 3'd1;
    end
    // ****************************************
    // Properties
    // ****************************************
    AST_PREADY: assert property (ce && psel && !penable |=> pready)
        else $error("ready missing in access cycle");
    AST_SLVERR: assert property (psel && penable && pready |->
        pslverr == (paddr > LTM_OFS_IRQMSK || paddr[1:0] != 2'b00))
        else $error("error response does not match address");
    AST_RST_QUIET: assert property ($rose(presetn) |-> !load_threshold_output && !irq)
        else $error("output active after reset");
    AST_NO_ASSIGN: assert property (!asg_q [*3] |=> !load_threshold_output)
        else $error("output driven while unassigned");
    AST_BAD_THRESH: assert property (
        (lo_q == 0 || hi_q == 0 || lo_q >= hi_q) [*3] |=> !load_threshold_output)
        else $error("output driven with unusable thresholds");
    AST_ENABLE_GATE: assert property (
        (en_q && !threshold_enable_input) [*3] |=> !load_threshold_output)
        else $error("output driven while enable contact off");
    AST_SETTLE_LOW: assert property (
        SEC_CYCLES >= 8 && en_q && set_q > 1
        && $rose(threshold_enable_input) |-> ##3 !load_threshold_output [*8])
        else $error("output not held low while settling");
    AST_SET_CAUSE: assert property (
        live_q == 3'd7 && $rose(load_threshold_output) |->
        (mode_q ? $past(power_pct, 2) > hi_q : $past(power_pct, 2) < lo_q))
        else $error("output set without qualifying power");
    AST_CLR_CAUSE: assert property (
        live_q == 3'd7 && $fell(load_threshold_output) |->
        (mode_q ? $past(power_pct, 2) < lo_q : $past(power_pct, 2) > hi_q))
        else $error("output cleared without qualifying power");
endmodule
bind ltm_top ltm_top_asserts #(.SEC_CYCLES(SEC_CYCLES)) ltm_top_asserts_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_pct(power_pct), .threshold_enable_input(threshold_enable_input),
    .load_threshold_output(load_threshold_output), .irq(irq));

/* File: testbench/tb.sv */
// Self-checking bench for the load threshold monitor.
// Assumes a shortened second of SC cycles and ce held high.
`timescale 1ns/10ps
module tb;
    import ltm_pkg::*;
    localparam int SC = 10;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, lto;
    logic        en_req, en_in, e_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic  [7:0] pwr_req, power_pct;
    logic        m_mode, m_en, m_asg, m_enin, m_out;
    int          m_lo, m_hi, m_ld, m_hd, num_errors, num_checks;
    ltm_top #(.SEC_CYCLES(SC)) ltm_top_i (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_pct(power_pct),
        .threshold_enable_input(en_in), .load_threshold_output(lto), .irq(irq));
    ltm_plant ltm_plant_i (.pclk(pclk), .presetn(presetn), .pwr_req(pwr_req),
        .en_req(en_req), .power_pct(power_pct), .en_contact(en_in));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask
    // ****************************************
    // APB master and model
    // ****************************************
    task apb(input logic w, input logic [11:0] a, input int d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 32'(d)};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        q = prdata;
        e_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("wait states", 32'h1, n);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 0);
        chk("read data", exp, q);
    endtask
    task cfg(input int md, input int en, input int asg, input int lo, input int ld,
             input int hi, input int hd, input int st);
        apb(1'b1, LTM_OFS_LOWTH, lo);
        apb(1'b1, LTM_OFS_LOWDLY, ld);
        apb(1'b1, LTM_OFS_HIGHTH, hi);
        apb(1'b1, LTM_OFS_HIGHDLY, hd);
        apb(1'b1, LTM_OFS_SETTLE, st);
        apb(1'b1, LTM_OFS_CTRL, md | en << 1 | asg << 2);
        {m_mode, m_en, m_asg, m_lo, m_ld, m_hi, m_hd} = {md[0], en[0], asg[0], lo, ld, hi, hd};
    endtask
    // Drive a power level, predict the output and watch it change
    task qual(input int pw);
        int n;
        int t;
        int d;
        if (!m_asg || m_lo == 0 || m_hi == 0 || m_lo >= m_hi || (m_en && !m_enin)) t = -1;
        else if (m_mode ? pw > m_hi : pw < m_lo) t = 1;
        else if (m_mode ? pw < m_lo : pw > m_hi) t = 0;
        else t = int'(m_out);
        d = (t[0] ^ m_mode) ? m_ld : m_hd;
        pwr_req <= 8'(pw);
        if (t >= 0 && t[0] !== m_out) begin
            repeat ((d - 1) * SC - 2) @(posedge pclk);
            chk("early output", {31'h0, m_out}, {31'h0, lto});
        end
        m_out = (t > 0);
        n = 0;
        while (lto !== m_out && n < 8 * SC) begin
            @(posedge pclk);
            n++;
        end
        repeat (4 * SC) @(posedge pclk);
        chk("output", {31'h0, m_out}, {31'h0, lto});
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12000) @(posedge pclk);
        num_errors++;
        $display("unexpected watchdog: expected end seen hang");
        wrap_up();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic [11:0] adr [8];
        adr = '{LTM_OFS_CTRL, LTM_OFS_LOWTH, LTM_OFS_LOWDLY, LTM_OFS_HIGHTH,
                LTM_OFS_HIGHDLY, LTM_OFS_SETTLE, LTM_OFS_IRQST, LTM_OFS_IRQMSK};
        {presetn, ce, psel, penable, pwrite, paddr, pwdata, pwr_req, en_req} = '0;
        // Park power inside the band so no delay runs while configuring
        pwr_req = 8'd50;
        {m_mode, m_en, m_asg, m_enin, m_out} = 5'b00100;
        ce = 1'b1;
        void'($urandom(94));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (adr[i]) rd(adr[i], (i == 0) ? 32'h4 : 32'h0);
        rd(12'h024, 32'h0);
        chk("error flag", 32'h1, {31'h0, e_q});
        $display("test reset done");
        apb(1'b1, LTM_OFS_IRQMSK, 1);
        cfg(0, 0, 1, 30, 3, 70, 2, 0);
        qual($urandom_range(29, 0));
        chk("irq", 32'h1, {31'h0, irq});
        rd(LTM_OFS_IRQST, 32'h1);
        apb(1'b1, LTM_OFS_IRQST, 1);
        repeat (3) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        qual(50);
        qual($urandom_range(100, 71));
        rd(LTM_OFS_IRQST, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        pwr_req <= 8'd10;
        repeat (2 * SC - 2) @(posedge pclk);
        pwr_req <= 8'd50;
        repeat (3) @(posedge pclk);
        pwr_req <= 8'd10;
        repeat (2 * SC - 2) @(posedge pclk);
        chk("lapsed output", 32'h0, {31'h0, lto});
        qual(50);
        qual(10);
        qual(90);
        $display("test low load done");
        cfg(1, 0, 1, 30, 2, 70, 3, 0);
        qual($urandom_range(100, 71));
        qual(50);
        qual($urandom_range(29, 0));
        $display("test high load done");
        cfg(0, 0, 1, 70, 2, 30, 2, 0);
        qual(10);
        cfg(0, 0, 1, 0, 2, 70, 2, 0);
        qual(10);
        cfg(0, 0, 0, 30, 2, 70, 2, 0);
        qual(10);
        $display("test disabled done");
        apb(1'b1, LTM_OFS_IRQST, 7);
        cfg(0, 1, 1, 30, 3, 70, 2, 2);
        qual(10);
        en_req <= 1'b1;
        m_enin = 1'b1;
        qual(10);
        rd(LTM_OFS_IRQST, 32'h5);
        rd(LTM_OFS_STATUS, 32'hB);
        chk("irq", 32'h1, {31'h0, irq});
        $display("test enable done");
        wrap_up();
    end
endmodule
